// ===== src/pst_sequencer.sv
// Purpose: Program sequencer with fetch pipeline, return stack and table reads
// Assumes: Program ROM read is combinational within one clock
// Notes:   Registers on APB; interrupt sources pulse on clk except ext pin
//
// What this block does
// - four phases make one instruction cycle
// - fetch overlaps execute; transfers take two cycles
// - counter advances by one after fetch
// - taken skip discards fetched word, dummy cycle
// - low byte write jumps within page, unless pending as a table read ends
// - reset clears counter to zero
// - external interrupt vectors to 004
// - timer overflow vectors to 008
// - converter done vectors to 00C
// - serial bus event vectors to 010
// - jump/call load code, return loads stack
// - ROM addressed by counter or table
// - current page table uses counter high bits
// - last page table forces high bits ones
// - table low byte to memory, high latched
// - pointer read/write, high latch read-only
// - table read takes two cycles
// - wake waits 1024 clocks before running
// - call or acknowledge pushes six-deep stack
// - full stack defers interrupts, call drops oldest
// - acknowledge clears global interrupt enable
`timescale 1ns/10ps
`include "pst_defs.svh"

module pst_sequencer
    import pst_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [10:0] rom_addr,
    input  wire logic [13:0] rom_data,
    input  wire pst_op_t     op,
    output logic      [13:0] instr,
    output logic             instr_valid,
    output logic      [3:0]  phase,
    output pst_dmw_t         dm_wr,
    input  wire logic        ext_int_pin,
    input  wire logic        tmr_ovf,
    input  wire logic        adc_done,
    input  wire logic        sbus_evt,
    output logic             halted
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    pst_phase_t  ph_q, ph_d;             // Phase within instruction cycle
    pst_state_t  st_q, st_d;             // Run, halt, wake
    logic [10:0] wake_q, wake_d;         // Start-up counter
    logic [10:0] pc_q, pc_d;             // Instruction pointer
    logic [13:0] ir_q, ir_d;             // Fetched instruction
    logic        irv_q, irv_d;           // Fetched instruction is live
    logic        tab_q, tab_d;           // Second table cycle pending
    logic [10:0] taddr_q, taddr_d;       // Table ROM address
    logic [6:0]  tdm_q, tdm_d;           // Table destination
    logic [5:0]  thib_q, thib_d;         // Table high latch
    logic [7:0]  tptr_q, tptr_d;         // Table pointer
    pst_dmw_t    dmw_q, dmw_d;           // Data memory write
    logic        pclp_q, pclp_d;         // Low byte write pending
    logic [7:0]  pclv_q, pclv_d;         // Low byte value
    logic [4:0]  ctrl_q, ctrl_d;         // Enables: GIE and sources
    logic [3:0]  pend_q, pend_d;         // Request flags
    logic [10:0] stk_q [0:`PST_STK_DEPTH-1]; // Return stack
    logic [10:0] stk_d [0:`PST_STK_DEPTH-1];
    logic [2:0]  sidx_q, sidx_d;         // Stack index
    logic        push, pop;              // Stack moves
    logic [10:0] push_val;               // Pushed address
    logic [2:0]  xs_q;                   // External pin synchroniser
    logic [31:0] rd_q, rd_d;             // APB read data
    logic        err_q, err_d;           // APB error
    logic        cyc_end;                // Last clock of instruction
    logic        irq_ok;                 // Interrupt may be taken
    logic [3:0]  ack;                    // One-hot acknowledge
    logic [10:0] vec;                    // Selected vector
    logic        apb_wr;                 // APB write in access phase
    pst_rsel_t   wsel;                   // Write target

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Address decode shared by read and write
    function automatic pst_rsel_t reg_sel(input logic [11:0] a);
        pst_rsel_t s;
        s = PST_R_NONE;
        if (a[1:0] == 2'b00) begin
            unique case (a[11:2])
                `PST_IDX_PCLO: s = PST_R_PCLO;
                `PST_IDX_TPTR: s = PST_R_TPTR;
                `PST_IDX_THI:  s = PST_R_THI;
                `PST_IDX_CTRL: s = PST_R_CTRL;
                `PST_IDX_STAT: s = PST_R_STAT;
                default:       s = PST_R_NONE;
            endcase
        end
        return s;
    endfunction

    // Lowest vector first, one per acknowledge
    function automatic logic [3:0] pick(input logic [3:0] req);
        logic [3:0] g;
        g = 4'h0;
        if (req[0]) begin
            g = 4'h1;
        end else if (req[1]) begin
            g = 4'h2;
        end else if (req[2]) begin
            g = 4'h4;
        end else if (req[3]) begin
            g = 4'h8;
        end
        return g;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign phase       = ph_q;
    assign instr       = ir_q;
    assign instr_valid = irv_q & ~tab_q & (st_q == PST_RUN);
    assign dm_wr       = dmw_q;
    assign halted      = (st_q != PST_RUN);
    assign prdata      = rd_q;
    assign pready      = 1'b1;
    assign pslverr     = psel & penable & err_q;
    // ROM is shared by fetch and table read
    assign rom_addr    = tab_q ? taddr_q : pc_q;

    ////////////////////////////////////////////////////////////////////////
    // Phase, halt and wake sequencing
    assign cyc_end = (st_q == PST_RUN) && (ph_q == PST_PH3);

    always_comb begin
        ph_d   = ph_q;
        st_d   = st_q;
        wake_d = wake_q;
        unique case (st_q)
            PST_RUN: begin
                // Four clocks per instruction cycle
                unique case (ph_q)
                    PST_PH0: ph_d = PST_PH1;
                    PST_PH1: ph_d = PST_PH2;
                    PST_PH2: ph_d = PST_PH3;
                    PST_PH3: ph_d = PST_PH0;
                endcase
                if (cyc_end && !tab_q && irv_q && op.kind == PST_OP_HALT) begin
                    st_d = PST_HALT;
                end
            end
            PST_HALT: begin
                // Any enabled request wakes the core
                if (|(pend_q & ctrl_q[4:1])) begin
                    st_d   = PST_WAKE;
                    wake_d = 11'(`PST_WAKE_CYC - 1);
                end
            end
            PST_WAKE: begin
                // Start-up period before resuming
                if (wake_q == 11'h000) begin
                    st_d = PST_RUN;
                end else begin
                    wake_d = wake_q - 11'h001;
                end
            end
            default: st_d = PST_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ph_q   <= PST_PH0;
            st_q   <= PST_RUN;
            wake_q <= 11'h000;
        end else begin
            ph_q   <= ph_d;
            st_q   <= st_d;
            wake_q <= wake_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt requests and acknowledge
    assign irq_ok = ctrl_q[`PST_CTRL_GIE] && (sidx_q != `PST_STK_FULL) && !tab_q
                  && !pclp_q && (!irv_q || op.kind == PST_OP_NONE);
    // Not on a skip: the discarded word must not be resumed
    // Full stack withholds the acknowledge only
    assign ack = (cyc_end && irq_ok) ? pick(pend_q & ctrl_q[4:1]) : 4'h0;

    always_comb begin
        unique case (ack)
            4'h1:    vec = `PST_VEC_EXT;
            4'h2:    vec = `PST_VEC_TMR;
            4'h4:    vec = `PST_VEC_ADC;
            4'h8:    vec = `PST_VEC_SBUS;
            default: vec = `PST_VEC_RESET;
        endcase
    end

    always_comb begin
        // Set wins over acknowledge clear; flags kept while blocked
        pend_d = (pend_q & ~ack)
               | {sbus_evt, adc_done, tmr_ovf, xs_q[1] & ~xs_q[2]};
        ctrl_d = ctrl_q;
        if (apb_wr && wsel == PST_R_CTRL) begin
            ctrl_d = pwdata[4:0];
        end
        if (cyc_end && irv_q && !tab_q && op.kind == PST_OP_RETI) begin
            ctrl_d[`PST_CTRL_GIE] = 1'b1;
        end
        if (|ack) begin
            ctrl_d[`PST_CTRL_GIE] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            xs_q   <= 3'h0;
            pend_q <= 4'h0;
            ctrl_q <= `PST_CTRL_RST;
        end else begin
            xs_q   <= {xs_q[1:0], ext_int_pin};
            pend_q <= pend_d;
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter, fetch and table read
    always_comb begin
        pc_d     = pc_q;
        ir_d     = ir_q;
        irv_d    = irv_q;
        tab_d    = tab_q;
        taddr_d  = taddr_q;
        tdm_d    = tdm_q;
        thib_d   = thib_q;
        dmw_d    = '0;
        push     = 1'b0;
        pop      = 1'b0;
        push_val = pc_q;
        if (cyc_end) begin
            // Fetch while the previous word executes
            pc_d  = pc_q + 11'h001; // wraps at top
            ir_d  = rom_data;
            irv_d = 1'b1;
            if (tab_q) begin
                // Second table cycle: ROM serves the table
                pc_d   = pc_q;
                ir_d   = ir_q;
                tab_d  = 1'b0;
                thib_d = rom_data[13:8];
                dmw_d  = '{valid: 1'b1, addr: tdm_q, data: rom_data[7:0]};
            end else if (pclp_q) begin
                pc_d  = {pc_q[10:8], pclv_q};
                irv_d = 1'b0;
            end else if (|ack) begin
                push  = 1'b1;
                pc_d  = vec;
                irv_d = 1'b0;
            end else if (irv_q) begin
                unique case (op.kind)
                    PST_OP_JUMP: begin
                        pc_d  = op.target;
                        irv_d = 1'b0;
                    end
                    PST_OP_CALL: begin
                        push  = 1'b1;
                        pc_d  = op.target;
                        irv_d = 1'b0;
                    end
                    PST_OP_RET, PST_OP_RETI: begin
                        pop   = 1'b1;
                        pc_d  = stk_q[0];
                        irv_d = 1'b0;
                    end
                    PST_OP_SKIP: begin
                        irv_d = 1'b0;
                    end
                    PST_OP_TABC: begin
                        tab_d   = 1'b1;
                        taddr_d = {pc_q[10:8], tptr_q};
                        tdm_d   = op.dm_addr;
                    end
                    PST_OP_TABL: begin
                        tab_d   = 1'b1;
                        taddr_d = {`PST_LAST_PAGE, tptr_q};
                        tdm_d   = op.dm_addr;
                    end
                    PST_OP_HALT, PST_OP_NONE: begin
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pc_q    <= `PST_VEC_RESET;
            ir_q    <= 14'h0000;
            irv_q   <= 1'b0;
            tab_q   <= 1'b0;
            taddr_q <= 11'h000;
            tdm_q   <= 7'h00;
            thib_q  <= 6'h00;
            dmw_q   <= '0;
        end else begin
            pc_q    <= pc_d;
            ir_q    <= ir_d;
            irv_q   <= irv_d;
            tab_q   <= tab_d;
            taddr_q <= taddr_d;
            tdm_q   <= tdm_d;
            thib_q  <= thib_d;
            dmw_q   <= dmw_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Return stack: entry 0 is the top; push on full drops oldest
    always_comb begin
        sidx_d = sidx_q;
        if (push && sidx_q != `PST_STK_FULL) begin
            sidx_d = sidx_q + 3'h1;
        end else if (pop && sidx_q != 3'h0) begin
            sidx_d = sidx_q - 3'h1;   // frees room for deferred requests
        end
    end

    for (genvar i = 0; i < `PST_STK_DEPTH; i++) begin : g_stk
        always_comb begin
            stk_d[i] = stk_q[i];
            if (push) begin
                // Shift down; last entry falls off
                stk_d[i] = (i == 0) ? push_val : stk_q[(i == 0) ? 0 : i - 1];
            end else if (pop) begin
                stk_d[i] = (i == `PST_STK_DEPTH - 1) ? stk_q[i]
                         : stk_q[(i == `PST_STK_DEPTH - 1) ? i : i + 1];
            end
        end
        always_ff @(posedge clk) begin
            if (!nrst) begin
                stk_q[i] <= 11'h000;
            end else begin
                stk_q[i] <= stk_d[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sidx_q <= 3'h0;
        end else begin
            sidx_q <= sidx_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in setup
    assign apb_wr = psel & penable & pwrite;
    assign wsel   = reg_sel(paddr);

    always_comb begin
        rd_d   = rd_q;
        err_d  = err_q;
        tptr_d = tptr_q;
        pclp_d = pclp_q;
        pclv_d = pclv_q;
        if (cyc_end) begin
            pclp_d = 1'b0;
        end
        if (psel && !penable) begin
            err_d = (wsel == PST_R_NONE);
            rd_d  = 32'h0000_0000;
            unique case (wsel)
                PST_R_PCLO: rd_d[7:0] = pc_q[7:0];
                PST_R_TPTR: rd_d[7:0] = tptr_q;
                PST_R_THI:  rd_d[7:0] = {2'b00, thib_q};
                PST_R_CTRL: rd_d[4:0] = ctrl_q;
                PST_R_STAT: rd_d[7:0] = {halted, sidx_q, pend_q};
                PST_R_NONE: rd_d      = 32'h0000_0000;
            endcase
        end
        if (apb_wr) begin
            unique case (wsel)
                PST_R_PCLO: begin
                    pclp_d = 1'b1;            // applied at cycle end; cleared unapplied at table read end
                    pclv_d = pwdata[7:0];
                end
                PST_R_TPTR: tptr_d = pwdata[7:0];
                PST_R_THI, PST_R_CTRL, PST_R_STAT, PST_R_NONE: begin
                    // Latch and status ignore writes
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_q   <= 32'h0000_0000;
            err_q  <= 1'b0;
            tptr_q <= `PST_TPTR_RST;
            pclp_q <= 1'b0;
            pclv_q <= 8'h00;
        end else begin
            rd_q   <= rd_d;
            err_q  <= err_d;
            tptr_q <= tptr_d;
            pclp_q <= pclp_d;
            pclv_q <= pclv_d;
        end
    end

endmodule

// ===== src/pst_defs.svh
// Purpose: Offsets, vectors, reset values and timing counts for the sequencer
// Assumes: APB byte address is four times the register index
// Notes:   Definitions only
`ifndef PST_DEFS_SVH
`define PST_DEFS_SVH

// Register indices (byte address = 4 * index)
`define PST_IDX_PCLO      10'h006
`define PST_IDX_TPTR      10'h007
`define PST_IDX_THI       10'h008
`define PST_IDX_CTRL      10'h009
`define PST_IDX_STAT      10'h00A

// Control register fields
`define PST_CTRL_GIE      0
`define PST_CTRL_EN_LSB   1

// Program counter vectors
`define PST_VEC_RESET     11'h000
`define PST_VEC_EXT       11'h004
`define PST_VEC_TMR       11'h008
`define PST_VEC_ADC       11'h00C
`define PST_VEC_SBUS      11'h010
`define PST_LAST_PAGE     3'h7

// Reset values
`define PST_CTRL_RST      5'h00
`define PST_TPTR_RST      8'h00

// Return stack depth
`define PST_STK_DEPTH     6
`define PST_STK_FULL      3'h6

// Wake-up start-up period in system clock periods
`define PST_WAKE_TSYS     1024
`define PST_CLK_PER_TSYS  1
`define PST_WAKE_CYC      (`PST_WAKE_TSYS * `PST_CLK_PER_TSYS)

`endif

// ===== src/pst_pkg.sv
// Purpose: Types shared by the program sequencer
// Assumes: Constants come from pst_defs.svh
// Notes:   One-hot encodings written out
package pst_pkg;

    // Decoded control operation from the execute stage
    typedef enum logic [3:0] {
        PST_OP_NONE = 4'h0,
        PST_OP_JUMP = 4'h1,
        PST_OP_CALL = 4'h2,
        PST_OP_RET  = 4'h3,
        PST_OP_RETI = 4'h4,
        PST_OP_SKIP = 4'h5,
        PST_OP_TABC = 4'h6,
        PST_OP_TABL = 4'h7,
        PST_OP_HALT = 4'h8
    } pst_kind_t;

    typedef struct packed {
        pst_kind_t   kind;
        logic [10:0] target;
        logic [6:0]  dm_addr;
    } pst_op_t;

    // Data memory write from a table read
    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic [7:0] data;
    } pst_dmw_t;

    typedef enum logic [3:0] {
        PST_PH0 = 4'b0001,
        PST_PH1 = 4'b0010,
        PST_PH2 = 4'b0100,
        PST_PH3 = 4'b1000
    } pst_phase_t;

    typedef enum logic [2:0] {
        PST_RUN  = 3'b001,
        PST_HALT = 3'b010,
        PST_WAKE = 3'b100
    } pst_state_t;

    typedef enum logic [5:0] {
        PST_R_NONE = 6'b000000,
        PST_R_PCLO = 6'b000001,
        PST_R_TPTR = 6'b000010,
        PST_R_THI  = 6'b000100,
        PST_R_CTRL = 6'b001000,
        PST_R_STAT = 6'b010000
    } pst_rsel_t;

endpackage

// ===== verif/pst_rom_model.sv
// Purpose: Behavioural program ROM beside the sequencer
// Assumes: Read is combinational, as the sequencer expects
// Notes:   Word pattern makes high and low halves differ per address
`timescale 1ns/10ps

module pst_rom_model (
    input  wire logic [10:0] rom_addr,
    output logic      [13:0] rom_data
);
    // High six bits scrambled so a wrong page shows in the latch
    assign rom_data = {rom_addr[10:5] ^ 6'h15, rom_addr[7:0]};
endmodule

// ===== verif/pst_sequencer_props.sv
// Purpose: Concurrent checks on the sequencer ports
// Assumes: Ops are taken at the edge that ends phase three
// Notes:   Halt length is counted in helper logic
`timescale 1ns/10ps
`include "pst_defs.svh"

module pst_sequencer_props
    import pst_pkg::*;
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [10:0] rom_addr,
    input wire logic [13:0] rom_data,
    input wire pst_op_t     op,
    input wire logic [13:0] instr,
    input wire logic        instr_valid,
    input wire logic [3:0]  phase,
    input wire pst_dmw_t    dm_wr,
    input wire logic        halted
);
    logic [11:0] hcnt_q;  // Clocks spent halted, saturating
    logic [11:0] hcnt_d;
    logic        tk;      // Op taken at this edge

    ////////////////////////////////////////////////////////////////////////////////
    // Halt length counter
    always_comb begin
        hcnt_d = halted ? ((hcnt_q == 12'hFFF) ? hcnt_q : hcnt_q + 12'h001) : 12'h000;
    end
    always_ff @(posedge clk) begin
        hcnt_q <= nrst ? hcnt_d : 12'h000;
    end
    assign tk = (phase == PST_PH3) && instr_valid && !halted;

    ////////////////////////////////////////////////////////////////////////////////
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_reset_start: assert property (
        $rose(nrst) |-> rom_addr == `PST_VEC_RESET && phase == PST_PH0 && !instr_valid)
        else $error("counter or phase wrong after reset");
    chk_phase_cycle: assert property (
        !halted && phase == PST_PH0 |=> phase == PST_PH1 ##1 phase == PST_PH2
        ##1 phase == PST_PH3) else $error("phase sequence broken");
    chk_instr_stable: assert property (
        !halted && phase != PST_PH3 |=> $stable(instr) && $stable(instr_valid))
        else $error("instruction changed inside a cycle");
    chk_fetch_incr: assert property (
        tk && op.kind == PST_OP_NONE ##1 instr_valid |-> rom_addr == $past(rom_addr) + 11'h001)
        else $error("counter did not advance by one");
    chk_jump_target: assert property (
        tk && op.kind inside {PST_OP_JUMP, PST_OP_CALL} |=> !instr_valid
        && rom_addr == $past(op.target)) else $error("transfer target wrong");
    chk_skip_discard: assert property (
        tk && op.kind == PST_OP_SKIP |=> !instr_valid && rom_addr == $past(rom_addr) + 11'h001)
        else $error("skip did not discard fetched word");
    chk_table_write: assert property (
        tk && op.kind inside {PST_OP_TABC, PST_OP_TABL} |-> ##5 dm_wr.valid
        && dm_wr.addr == $past(op.dm_addr, 5) && dm_wr.data == $past(rom_data[7:0])
        ##1 !dm_wr.valid) else $error("table low byte write wrong");
    chk_last_page: assert property (
        tk && op.kind == PST_OP_TABL |=> rom_addr[10:8] == `PST_LAST_PAGE && !instr_valid)
        else $error("last page table address wrong");
    chk_wake_delay: assert property (
        $fell(halted) |-> hcnt_q >= 12'h400 && phase == PST_PH0)
        else $error("resumed before start-up period");
endmodule

bind pst_sequencer pst_sequencer_props pst_sequencer_props_inst (.clk(clk), .nrst(nrst),
    .rom_addr(rom_addr), .rom_data(rom_data), .op(op), .instr(instr),
    .instr_valid(instr_valid), .phase(phase), .dm_wr(dm_wr), .halted(halted));

// ===== verif/test_program_sequencer_table_read.sv
// Purpose: Self-checking bench for the program sequencer
// Assumes: Bench acts as decoder, one op per cycle end
// Notes:   Seeded random targets, pointers and memory addresses
`timescale 1ns/10ps
`include "pst_defs.svh"

module test_program_sequencer_table_read import pst_pkg::*; ();
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, instr_valid, halted, er;
    logic        ext_int_pin, tmr_ovf, adc_done, sbus_evt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [10:0] rom_addr, a, t;
    logic [13:0] rom_data, instr, w;
    logic [3:0]  phase;
    logic [7:0]  p;
    logic [6:0]  d;
    pst_op_t     op;
    pst_dmw_t    dm_wr;
    int          err_total, n_checks, cnt;
    logic [10:0] vec [4] = '{`PST_VEC_EXT, `PST_VEC_TMR, `PST_VEC_ADC, `PST_VEC_SBUS};

    pst_sequencer pst_sequencer_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rom_addr(rom_addr), .rom_data(rom_data), .op(op), .instr(instr),
        .instr_valid(instr_valid), .phase(phase), .dm_wr(dm_wr), .ext_int_pin(ext_int_pin),
        .tmr_ovf(tmr_ovf), .adc_done(adc_done), .sbus_evt(sbus_evt), .halted(halted));
    pst_rom_model pst_rom_model_inst (.rom_addr(rom_addr), .rom_data(rom_data));

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    always #20 clk = ~clk;
    function automatic logic [13:0] rom_word(input logic [10:0] ad);
        return {ad[10:5] ^ 6'h15, ad[7:0]};
    endfunction
    function automatic logic [11:0] ra(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Setup, access until pready, then release
    task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
             output logic [31:0] rdv, output logic erv);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, ad, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task end_cyc;
        do @(posedge clk); while (phase !== PST_PH3);
    endtask
    // Hold op until a live instruction takes it
    task exec(input pst_kind_t k, input logic [10:0] tg, input logic [6:0] dm);
        @(posedge clk);
        op <= '{kind: k, target: tg, dm_addr: dm};
        do end_cyc(); while (instr_valid !== 1'b1);
        op <= '{kind: PST_OP_NONE, target: 11'h000, dm_addr: 7'h00};
    endtask
    initial begin
        #800000;
        err_total++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {clk, nrst, psel, penable, pwrite, ext_int_pin, tmr_ovf, adc_done, sbus_evt} = '0;
        paddr = '0;
        pwdata = '0;
        op = '0;
        err_total = 0;
        n_checks = 0;
        cnt = $urandom(85);
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("pc", rom_addr, `PST_VEC_RESET);
        repeat (6) begin
            a = rom_addr;
            end_cyc();
            #1;
            chk("fetch", instr, rom_word(a));
            chk("incr", rom_addr, a + 11'h001);
        end
        $display("test fetch done");
        for (int i = 0; i < 3; i++) begin
            t = (i == 0) ? 11'h7FF : 11'($urandom);
            exec(PST_OP_JUMP, t, 7'h00);
            #1;
            chk("jump", {instr_valid, rom_addr}, {1'b0, t});
            end_cyc();
            #1;
            chk("target", instr, rom_word(t));
            t = t + 11'h001;
            chk("wrap", rom_addr, t);
        end
        a = rom_addr + 11'h001;
        exec(PST_OP_SKIP, 11'h000, 7'h00);
        #1;
        chk("skip", {instr_valid, rom_addr}, {1'b0, a});
        for (int i = 1; i <= 7; i++) begin
            end_cyc();
            #1;
            a = rom_addr;
            exec(PST_OP_CALL, 11'($urandom), 7'h00);
            apb(1'b0, ra(`PST_IDX_STAT), 32'h0000_0000, rd, er);
            chk("depth", rd[6:4], (i > 6) ? 6 : i);
        end
        exec(PST_OP_RET, 11'h000, 7'h00);
        #1;
        chk("ret", rom_addr, a);
        $display("test calls done");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("reset", rom_addr, `PST_VEC_RESET);
        exec(PST_OP_JUMP, 11'h520, 7'h00);
        end_cyc();
        p = 8'($urandom) & 8'h7F;
        apb(1'b1, ra(`PST_IDX_PCLO), {24'h0000_00, p}, rd, er);
        end_cyc();
        #1;
        chk("short", rom_addr, {3'h5, p});
        for (int k = 0; k < 2; k++) begin // global enable off here
            p = 8'($urandom);
            d = 7'($urandom);
            apb(1'b1, ra(`PST_IDX_TPTR), {24'h0000_00, p}, rd, er);
            apb(1'b1, ra(`PST_IDX_THI), 32'hFFFF_FFFF, rd, er);
            apb(1'b0, ra(`PST_IDX_TPTR), 32'h0000_0000, rd, er);
            chk("pointer", rd, {24'h0000_00, p});
            exec(k ? PST_OP_TABL : PST_OP_TABC, 11'h000, d);
            #1;
            t = {k ? 3'h7 : 3'h5, p};
            chk("taddr", {instr_valid, rom_addr}, {1'b0, t});
            w = rom_word(t);
            end_cyc();
            #1;
            chk("dmw", dm_wr, {1'b1, d, w[7:0]});
            apb(1'b0, ra(`PST_IDX_THI), 32'h0000_0000, rd, er);
            chk("latch", rd, {26'h000_0000, w[13:8]});
        end
        apb(1'b0, 12'hFFC, 32'h0000_0000, rd, er);
        chk("unmapped", er, 1'b1);
        $display("test tables done");
        apb(1'b1, ra(`PST_IDX_CTRL), 32'h0000_001E, rd, er);
        @(posedge clk);
        {ext_int_pin, tmr_ovf, adc_done, sbus_evt} <= 4'hF;
        @(posedge clk);
        {tmr_ovf, adc_done, sbus_evt} <= 3'h0;
        repeat (4) @(posedge clk);
        apb(1'b0, ra(`PST_IDX_STAT), 32'h0000_0000, rd, er);
        chk("pending", rd[3:0], 4'hF);
        apb(1'b1, ra(`PST_IDX_CTRL), 32'h0000_001F, rd, er);
        for (int i = 0; i < 4; i++) begin
            cnt = 0;
            while (rom_addr !== vec[i] && cnt < 60) begin
                @(posedge clk);
                #1;
                cnt++;
            end
            chk("vector", rom_addr, vec[i]);
            apb(1'b0, ra(`PST_IDX_CTRL), 32'h0000_0000, rd, er);
            chk("gie", rd[0], 1'b0);
            exec(PST_OP_RETI, 11'h000, 7'h00);
        end
        ext_int_pin <= 1'b0;
        $display("test interrupts done");
        apb(1'b1, ra(`PST_IDX_CTRL), 32'h0000_0004, rd, er);
        exec(PST_OP_HALT, 11'h000, 7'h00);
        #1;
        chk("halt", halted, 1'b1);
        @(posedge clk);
        tmr_ovf <= 1'b1;
        @(posedge clk);
        tmr_ovf <= 1'b0;
        cnt = 0;
        while (halted !== 1'b0 && cnt < 1100) begin
            @(posedge clk);
            cnt++;
        end
        chk("wake", cnt >= 1020 && cnt <= 1030, 1'b1);
        $display("test halt done");
        report_and_stop();
    end
endmodule
